// ---- bench/bru_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module bru_mon (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [7:0]  awaddr,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [31:0] wdata,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [7:0]  araddr,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        resolved,
   input wire logic        branch_taken,
   input wire logic [31:0] redirect_pc
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_go;
      s_wr ##0 (awaddr == bru_pkg::CTRL_OFS && wdata[0]);
   endsequence
   sequence s_rd;
      arvalid && arready;
   endsequence
   a_write_resp: assert property (s_wr |-> ##2 bvalid)
      else $error("write answer late");
   a_read_local: assert property (s_rd ##0 (araddr < 8'h40) |=> rvalid)
      else $error("local read answer late");
   a_read_greg: assert property (s_rd ##0 (araddr[7:6] == 2'b01 && araddr[1:0] == 2'b00)
      |=> (!rvalid ##1 (rvalid && rresp == 2'b00)) or (rvalid && rresp == 2'b10))
      else $error("register read answer wrong cycle");
   a_read_decerr: assert property (s_rd ##0 (araddr == 8'h20) |=> rresp == 2'b11 && rdata == 0)
      else $error("unmapped read not refused");
   a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   a_go_result: assert property (s_go |-> ##1 (!resolved)[*7] ##1 resolved)
      else $error("resolution timing wrong");
   a_pulse_once: assert property (resolved |=> !resolved)
      else $error("resolved longer than a cycle");
   a_result_load: assert property ($changed(redirect_pc) || $changed(branch_taken) |-> resolved)
      else $error("result changed outside resolution");
endmodule // bru_mon
bind bru_top bru_mon u_mon (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
   .wdata, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
   .rresp, .resolved, .branch_taken, .redirect_pc);
`default_nettype wire

// ---- bench/bru_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module bru_top_tb_top;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        awready, wready, bvalid, arready, rvalid, resolved, branch_taken;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata, redirect_pc, d;
   logic [31:0] gr[16];
   int          n_mismatch = 0, checked = 0;
   bru_top u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
      .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
      .rdata, .rresp, .resolved, .branch_taken, .redirect_pc);
   always #2 aclk = ~aclk;
   task automatic close_out;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic hang(input int n);
      if (n >= 60)
      begin
         n_mismatch++;
         close_out();
      end
   endtask
   // a master of random speed: its ready is either high from the start or raised once the answer stands
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= v;
      wstrb <= s;
      bready <= 1'($urandom);
      do
      begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1 && n < 60);
      if (!bready)
      begin
         bready <= 1'b1;
         @(posedge aclk);
      end
      r = bresp;
      bready <= 1'b0;
      hang(n);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'($urandom);
      do
      begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1 && n < 60);
      if (!rready)
      begin
         rready <= 1'b1;
         @(posedge aclk);
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      hang(n);
   endtask
   // returns taken, writeback, next address, writeback value
   function automatic logic [65:0] model(input logic [7:0] op, input logic [3:0] f1, f2, fl,
                                         input logic [31:0] loc, opa, input logic rx3, sgn);
      logic [31:0] seq, tgt, ni, lim;
      logic        t, tk, w, le, fls;
      t = |(f1 & fl);
      fls = op[5] ? op[1] : op[0];
      seq = loc + ((op[7:6] == 2'b00) ? 32'h2 : (rx3 ? 32'h6 : 32'h4));
      tgt = op[5] ? (op[0] ? loc + {f2, 1'b0} : loc - {f2, 1'b0})
                  : ((op[7:6] == 2'b00) ? gr[f2] : opa);
      ni = gr[f1] + gr[4'(f1 + 4'h1)];
      lim = gr[4'(f1 + 4'h2)];
      le = sgn ? ($signed(ni) <= $signed(lim)) : (ni <= lim);
      w = op[7] | (op[3:0] == 4'h1 && !op[5]);
      tk = op[7] ? (le ^ !op[0]) : (w ? 1'b1 : (t ^ fls));
      return {tk, w, (tk ? tgt : seq), (op[7] ? ni : seq)};
   endfunction
   task automatic run(input logic [7:0] op, input logic [3:0] f1, input logic [3:0] f2);
      logic [3:0]  fl;
      logic [31:0] loc, opa;
      logic        rx3, sgn;
      logic [65:0] e;
      fl = 4'($urandom);
      loc = $urandom & 32'hfffffffe;
      opa = $urandom & 32'hfffffffe;
      rx3 = 1'($urandom);
      sgn = 1'($urandom);
      for (int i = 0; i < 16; i++)
      begin
         gr[i] = $urandom & 32'hfffffffe;
         wr(bru_pkg::GREG_OFS + 8'(4 * i), gr[i], 4'hf);
      end
      wr(bru_pkg::FLAGS_OFS, {28'h0, fl}, 4'hf);
      wr(bru_pkg::LOC_OFS, loc, 4'hf);
      wr(bru_pkg::OPADR_OFS, opa, 4'hf);
      wr(bru_pkg::INSTR_OFS, {op, f1, f2, 16'h0}, 4'hf);
      e = model(op, f1, f2, fl, loc, opa, rx3, sgn);
      wr(bru_pkg::CTRL_OFS, {29'h0, sgn, rx3, 1'b1}, 4'hf);
      d = 32'h0;
      for (int k = 0; k < 20 && d[1] !== 1'b1; k++) rd(bru_pkg::STAT_OFS);
      hang(d[1] === 1'b1 ? 0 : 60);
      chk({31'h0, branch_taken}, {31'h0, e[65]});
      chk(redirect_pc, e[63:32]);
      rd(bru_pkg::NXTPC_OFS);
      chk(d, e[63:32]);
      rd(bru_pkg::FLAGS_OFS);
      chk(d & 32'hf, {28'h0, fl});
      rd(bru_pkg::GREG_OFS + 8'({f1, 2'b00}));
      chk(d, e[64] ? e[31:0] : gr[f1]);
      $display("test op %h done", op);
   endtask
   initial
   begin
      logic [7:0] ops[12];
      ops = '{8'h42, 8'h02, 8'h20, 8'h21, 8'h43, 8'h03, 8'h22, 8'h23, 8'h41, 8'h01, 8'hc1, 8'hc0};
      void'($urandom(68));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 36; i++) run(ops[i % 12], 4'($urandom), 4'($urandom));
      run(8'h01, 4'h5, 4'h5);
      run(8'hc1, 4'hf, 4'h0);
      run(8'hc0, 4'he, 4'h0);
      // unmapped places and a partial register write are refused
      wr(8'h20, 32'h1, 4'hf);
      chk({30'h0, r}, {30'h0, bru_pkg::RESP_DECERR});
      rd(8'h20);
      chk({30'h0, r}, {30'h0, bru_pkg::RESP_DECERR});
      wr(8'h44, 32'h1, 4'h3);
      chk({30'h0, r}, {30'h0, bru_pkg::RESP_SLVERR});
      $display("test refusals done");
      // an undecoded opcode falls through, and a write during resolution is refused
      wr(bru_pkg::LOC_OFS, 32'h100, 4'hf);
      wr(bru_pkg::INSTR_OFS, 32'h44000000, 4'hf);
      wr(bru_pkg::CTRL_OFS, 32'h1, 4'hf);
      wr(bru_pkg::FLAGS_OFS, 32'hf, 4'hf);
      chk({30'h0, r}, {30'h0, bru_pkg::RESP_SLVERR});
      repeat (12) @(posedge aclk);
      rd(bru_pkg::STAT_OFS);
      chk(d & 32'hf, 32'ha);
      chk(redirect_pc, 32'h104);
      $display("test illegal done");
      close_out();
   end
endmodule // bru_top_tb_top
`default_nettype wire

// ---- pkg/bru_pkg.sv ----
package bru_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] INSTR_OFS = 8'h04;
   localparam logic [7:0] LOC_OFS   = 8'h08;
   localparam logic [7:0] OPADR_OFS = 8'h0c;
   localparam logic [7:0] FLAGS_OFS = 8'h10;
   localparam logic [7:0] STAT_OFS  = 8'h14;
   localparam logic [7:0] NXTPC_OFS = 8'h18;
   localparam logic [7:0] GREG_OFS  = 8'h40;
   localparam logic [7:0] GREG_SPAN = 8'h40;

   localparam int CTRL_GO  = 0;
   localparam int CTRL_RX3 = 1;
   localparam int CTRL_SGN = 2;

   localparam int ST_BUSY  = 0;
   localparam int ST_DONE  = 1;
   localparam int ST_TAKEN = 2;
   localparam int ST_ILL   = 3;

   localparam int OPC_LO = 24;
   localparam int R1_LO  = 20;
   localparam int R2_LO  = 16;

   localparam logic [31:0] LEN_SHORT = 32'h2;
   localparam logic [31:0] LEN_RX    = 32'h4;
   localparam logic [31:0] LEN_RX3   = 32'h6;
   localparam logic [31:0] WORD_RST  = 32'h0;
   localparam logic [3:0]  FLAGS_RST = 4'h0;
   localparam logic [2:0]  FETCH_LAST = 3'h4;

   localparam logic [7:0] OP_TRUE_RX    = 8'h42;
   localparam logic [7:0] OP_TRUE_RR    = 8'h02;
   localparam logic [7:0] OP_TRUE_BACK  = 8'h20;
   localparam logic [7:0] OP_TRUE_FWD   = 8'h21;
   localparam logic [7:0] OP_FALSE_RX   = 8'h43;
   localparam logic [7:0] OP_FALSE_RR   = 8'h03;
   localparam logic [7:0] OP_FALSE_BACK = 8'h22;
   localparam logic [7:0] OP_FALSE_FWD  = 8'h23;
   localparam logic [7:0] OP_LINK_RX    = 8'h41;
   localparam logic [7:0] OP_LINK_RR    = 8'h01;
   localparam logic [7:0] OP_LOOP_LE    = 8'hc1;
   localparam logic [7:0] OP_LOOP_HI    = 8'hc0;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   typedef enum logic [1:0] {
      BRU_IDLE  = 2'b00,
      BRU_FETCH = 2'b01,
      BRU_EXEC  = 2'b10
   } bru_state_t;
endpackage

// ---- verilog/bru_decide.sv ----
`timescale 1ns/1ps
`default_nettype none
module bru_decide (
   input  wire logic [7:0]  opcode,
   input  wire logic [3:0]  mask,
   input  wire logic [3:0]  flags,
   input  wire logic [31:0] new_index,
   input  wire logic [31:0] limit,
   input  wire logic        cmp_signed,
   output logic             is_short,
   output logic             is_back,
   output logic             is_rr,
   output logic             is_link,
   output logic             is_loop,
   output logic             legal,
   output logic             taken
);
   logic any_hit;
   logic not_above;

   always_comb
   begin
      // mask bits line up with c v g l, msb first
      any_hit   = |(mask & flags);
      not_above = cmp_signed ? ($signed(new_index) <= $signed(limit))
                             : (new_index <= limit);
      is_short  = 1'b0;
      is_back   = 1'b0;
      is_rr     = 1'b0;
      is_link   = 1'b0;
      is_loop   = 1'b0;
      legal     = 1'b1;
      taken     = 1'b0;
      case (opcode)
         bru_pkg::OP_TRUE_RX:    taken = any_hit;
         bru_pkg::OP_TRUE_RR:
         begin
            is_rr = 1'b1;
            taken = any_hit;
         end
         bru_pkg::OP_TRUE_BACK, bru_pkg::OP_TRUE_FWD:
         begin
            is_short = 1'b1;
            is_back  = (opcode == bru_pkg::OP_TRUE_BACK);
            taken    = any_hit;
         end
         bru_pkg::OP_FALSE_RX:   taken = !any_hit;
         bru_pkg::OP_FALSE_RR:
         begin
            is_rr = 1'b1;
            taken = !any_hit;
         end
         bru_pkg::OP_FALSE_BACK, bru_pkg::OP_FALSE_FWD:
         begin
            is_short = 1'b1;
            is_back  = (opcode == bru_pkg::OP_FALSE_BACK);
            taken    = !any_hit;
         end
         bru_pkg::OP_LINK_RX, bru_pkg::OP_LINK_RR:
         begin
            is_rr   = (opcode == bru_pkg::OP_LINK_RR);
            is_link = 1'b1;
            taken   = 1'b1;
         end
         bru_pkg::OP_LOOP_LE:
         begin
            is_loop = 1'b1;
            taken   = not_above;
         end
         bru_pkg::OP_LOOP_HI:
         begin
            is_loop = 1'b1;
            taken   = !not_above;
         end
         default: legal = 1'b0;
      endcase
   end
endmodule // bru_decide
`default_nettype wire

// ---- verilog/bru_regfile.sv ----
`timescale 1ns/1ps
`default_nettype none
module bru_regfile #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 32
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic                     we,
   input  wire logic [$clog2(DEPTH)-1:0] waddr,
   input  wire logic [WIDTH-1:0]         wdata,
   input  wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic      [WIDTH-1:0]         rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rdata_ff;

   if (DEPTH < 2 || WIDTH < 1)
   begin : g_chk
      $error("bru_regfile: unsupported geometry");
   end

   // array has no reset: contents are software state
   always_ff @(posedge aclk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rdata_ff <= '0;
      end
      else
      begin
         rdata_ff <= mem[raddr];
      end
   end

   assign rdata = rdata_ff;
endmodule // bru_regfile
`default_nettype wire

// ---- verilog/bru_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module bru_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             resolved,
   output logic             branch_taken,
   output logic [31:0]      redirect_pc
);
   logic               aw_held_ff;
   logic [7:0]         aw_addr_ff;
   logic               w_held_ff;
   logic [31:0]        w_data_ff;
   logic [3:0]         w_strb_ff;
   logic               bvalid_ff;
   logic [1:0]         bresp_ff;
   logic               rvalid_ff;
   logic [1:0]         rresp_ff;
   logic [31:0]        rdata_ff;
   logic               rd_pend_ff;
   logic               rx3_ff;
   logic               sgn_ff;
   logic [31:0]        instr_ff;
   logic [31:0]        loc_ff;
   logic [31:0]        opadr_ff;
   logic [3:0]         flags_ff;
   logic               done_ff;
   logic               taken_ff;
   logic               ill_ff;
   logic               resolved_ff;
   logic [31:0]        next_pc_ff;
   bru_pkg::bru_state_t state_ff;
   logic [2:0]         cnt_ff;
   logic [31:0]        idx_ff;
   logic [31:0]        inc_ff;
   logic [31:0]        lim_ff;
   logic [31:0]        r2v_ff;

   logic               busy;
   logic               wr_fire;
   logic [1:0]         wr_resp;
   logic               wr_do;
   logic               go;
   logic               ar_fire;
   logic [31:0]        rd_word;
   logic [7:0]         opcode;
   logic [3:0]         r1;
   logic [3:0]         r2;
   logic [3:0]         fetch_idx;
   logic [31:0]        new_index;
   logic [31:0]        seq_pc;
   logic [31:0]        disp;
   logic [31:0]        target;
   logic               exec_wb;
   logic [31:0]        wb_value;
   logic               mem_we;
   logic [3:0]         mem_waddr;
   logic [31:0]        mem_wdata;
   logic [3:0]         mem_raddr;
   logic [31:0]        mem_rdata;
   logic               d_short;
   logic               d_back;
   logic               d_rr;
   logic               d_link;
   logic               d_loop;
   logic               d_legal;
   logic               d_taken;

   function automatic logic is_greg(input logic [7:0] a);
      is_greg = (a >= bru_pkg::GREG_OFS) && (a < bru_pkg::GREG_OFS + bru_pkg::GREG_SPAN)
                && (a[1:0] == 2'h0);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      case (a)
         bru_pkg::CTRL_OFS, bru_pkg::INSTR_OFS, bru_pkg::LOC_OFS, bru_pkg::OPADR_OFS,
         bru_pkg::FLAGS_OFS, bru_pkg::STAT_OFS, bru_pkg::NXTPC_OFS: mapped = 1'b1;
         default: mapped = is_greg(a);
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++)
      begin
         merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   // ---------------- bus write side
   assign busy    = (state_ff != bru_pkg::BRU_IDLE);
   assign awready = !aw_held_ff;
   assign wready  = !w_held_ff;
   assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_do   = wr_fire && (wr_resp == bru_pkg::RESP_OKAY);
   assign go      = wr_do && (aw_addr_ff == bru_pkg::CTRL_OFS) && w_strb_ff[0]
                    && w_data_ff[bru_pkg::CTRL_GO];

   // bus writes to the registers are refused while a resolution is running
   always_comb
   begin
      if (busy)
         wr_resp = bru_pkg::RESP_SLVERR;
      else if (!mapped(aw_addr_ff))
         wr_resp = bru_pkg::RESP_DECERR;
      else if (is_greg(aw_addr_ff) && (w_strb_ff != 4'hf))
         wr_resp = bru_pkg::RESP_SLVERR;
      else
         wr_resp = bru_pkg::RESP_OKAY;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_held_ff  <= 1'b0;
         w_data_ff  <= bru_pkg::WORD_RST;
         w_strb_ff  <= '0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= awaddr;
         end
         else if (wr_fire)
            aw_held_ff <= 1'b0;
         if (wvalid && wready)
         begin
            w_held_ff <= 1'b1;
            w_data_ff <= wdata;
            w_strb_ff <= wstrb;
         end
         else if (wr_fire)
            w_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= bru_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_resp;
      end
      else if (bready)
         bvalid_ff <= 1'b0;
   end

   assign bvalid = bvalid_ff;
   assign bresp  = bresp_ff;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx3_ff   <= 1'b0;
         sgn_ff   <= 1'b0;
         instr_ff <= bru_pkg::WORD_RST;
         loc_ff   <= bru_pkg::WORD_RST;
         opadr_ff <= bru_pkg::WORD_RST;
      end
      else if (wr_do)
      begin
         case (aw_addr_ff)
            bru_pkg::CTRL_OFS:
            begin
               if (w_strb_ff[0])
               begin
                  rx3_ff <= w_data_ff[bru_pkg::CTRL_RX3];
                  sgn_ff <= w_data_ff[bru_pkg::CTRL_SGN];
               end
            end
            bru_pkg::INSTR_OFS: instr_ff <= merge(instr_ff, w_data_ff, w_strb_ff);
            bru_pkg::LOC_OFS:   loc_ff   <= merge(loc_ff, w_data_ff, w_strb_ff);
            bru_pkg::OPADR_OFS: opadr_ff <= merge(opadr_ff, w_data_ff, w_strb_ff);
            default: ;
         endcase
      end
   end

   // only software ever loads the flags; resolution just reads them
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags_ff <= bru_pkg::FLAGS_RST;
      else if (wr_do && (aw_addr_ff == bru_pkg::FLAGS_OFS) && w_strb_ff[0])
         flags_ff <= w_data_ff[3:0];
   end

   // ---------------- bus read side
   assign arready = !rvalid_ff && !rd_pend_ff;
   assign ar_fire = arvalid && arready;

   always_comb
   begin
      rd_word = '0;
      case (araddr)
         bru_pkg::CTRL_OFS:
         begin
            rd_word[bru_pkg::CTRL_RX3] = rx3_ff;
            rd_word[bru_pkg::CTRL_SGN] = sgn_ff;
         end
         bru_pkg::INSTR_OFS: rd_word = instr_ff;
         bru_pkg::LOC_OFS:   rd_word = loc_ff;
         bru_pkg::OPADR_OFS: rd_word = opadr_ff;
         bru_pkg::FLAGS_OFS: rd_word[3:0] = flags_ff;
         bru_pkg::STAT_OFS:
         begin
            rd_word[bru_pkg::ST_BUSY]  = busy;
            rd_word[bru_pkg::ST_DONE]  = done_ff;
            rd_word[bru_pkg::ST_TAKEN] = taken_ff;
            rd_word[bru_pkg::ST_ILL]   = ill_ff;
         end
         bru_pkg::NXTPC_OFS: rd_word = next_pc_ff;
         default: ;
      endcase
   end

   // register-file reads take one extra cycle through the memory when idle; while busy they get SLVERR at once
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_ff  <= 1'b0;
         rd_pend_ff <= 1'b0;
         rdata_ff   <= bru_pkg::WORD_RST;
         rresp_ff   <= bru_pkg::RESP_OKAY;
      end
      else if (rd_pend_ff)
      begin
         rd_pend_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= mem_rdata;
         rresp_ff   <= bru_pkg::RESP_OKAY;
      end
      else if (ar_fire)
      begin
         if (is_greg(araddr) && !busy)
            rd_pend_ff <= 1'b1;
         else
         begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            if (!mapped(araddr))
               rresp_ff <= bru_pkg::RESP_DECERR;
            else if (is_greg(araddr))
               rresp_ff <= bru_pkg::RESP_SLVERR;
            else
               rresp_ff <= bru_pkg::RESP_OKAY;
         end
      end
      else if (rready)
         rvalid_ff <= 1'b0;
   end

   assign rvalid = rvalid_ff;
   assign rdata  = rdata_ff;
   assign rresp  = rresp_ff;

   // ---------------- resolution engine
   assign opcode = instr_ff[bru_pkg::OPC_LO +: 8];
   assign r1     = instr_ff[bru_pkg::R1_LO +: 4];
   assign r2     = instr_ff[bru_pkg::R2_LO +: 4];

   // 4-bit index arithmetic wraps 15 to 0 by itself
   always_comb
   begin
      case (cnt_ff)
         3'h0:    fetch_idx = r1;
         3'h1:    fetch_idx = r1 + 4'h1;
         3'h2:    fetch_idx = r1 + 4'h2;
         default: fetch_idx = r2;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_ff <= bru_pkg::BRU_IDLE;
         cnt_ff   <= '0;
      end
      else
      begin
         case (state_ff)
            bru_pkg::BRU_IDLE:
            begin
               cnt_ff <= '0;
               if (go)
                  state_ff <= bru_pkg::BRU_FETCH;
            end
            bru_pkg::BRU_FETCH:
            begin
               cnt_ff <= cnt_ff + 3'h1;
               if (cnt_ff == bru_pkg::FETCH_LAST)
                  state_ff <= bru_pkg::BRU_EXEC;
            end
            bru_pkg::BRU_EXEC: state_ff <= bru_pkg::BRU_IDLE;
            default:           state_ff <= bru_pkg::BRU_IDLE;
         endcase
      end
   end

   // every operand is captured before any write-back
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         idx_ff <= bru_pkg::WORD_RST;
         inc_ff <= bru_pkg::WORD_RST;
         lim_ff <= bru_pkg::WORD_RST;
         r2v_ff <= bru_pkg::WORD_RST;
      end
      else if (state_ff == bru_pkg::BRU_FETCH)
      begin
         case (cnt_ff)
            3'h1:    idx_ff <= mem_rdata;
            3'h2:    inc_ff <= mem_rdata;
            3'h3:    lim_ff <= mem_rdata;
            3'h4:    r2v_ff <= mem_rdata;
            default: ;
         endcase
      end
   end

   bru_decide u_decide (
      .opcode     (opcode),
      .mask       (r1),
      .flags      (flags_ff),
      .new_index  (new_index),
      .limit      (lim_ff),
      .cmp_signed (sgn_ff),
      .is_short   (d_short),
      .is_back    (d_back),
      .is_rr      (d_rr),
      .is_link    (d_link),
      .is_loop    (d_loop),
      .legal      (d_legal),
      .taken      (d_taken)
   );

   assign new_index = idx_ff + inc_ff;
   assign seq_pc    = loc_ff + ((d_rr || d_short) ? bru_pkg::LEN_SHORT
                               : (rx3_ff ? bru_pkg::LEN_RX3 : bru_pkg::LEN_RX));
   assign disp      = {27'h0, r2, 1'b0};

   // targets are used as given; alignment is left to software
   always_comb
   begin
      if (d_short)
         target = d_back ? (loc_ff - disp) : (loc_ff + disp);
      else if (d_rr)
         target = r2v_ff;
      else
         target = opadr_ff;
   end

   assign exec_wb  = (state_ff == bru_pkg::BRU_EXEC) && d_legal && (d_link || d_loop);
   assign wb_value = d_link ? seq_pc : new_index;

   assign mem_we    = exec_wb || (wr_do && is_greg(aw_addr_ff));
   assign mem_waddr = busy ? r1 : aw_addr_ff[5:2];
   assign mem_wdata = busy ? wb_value : w_data_ff;
   assign mem_raddr = busy ? fetch_idx : araddr[5:2];

   bru_regfile #(
      .DEPTH (16),
      .WIDTH (bru_pkg::DATA_W)
   ) u_regs (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .raddr   (mem_raddr),
      .rdata   (mem_rdata)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         done_ff     <= 1'b0;
         taken_ff    <= 1'b0;
         ill_ff      <= 1'b0;
         resolved_ff <= 1'b0;
         next_pc_ff  <= bru_pkg::WORD_RST;
      end
      else if (state_ff == bru_pkg::BRU_EXEC)
      begin
         done_ff     <= 1'b1;
         resolved_ff <= 1'b1;
         taken_ff    <= d_legal && d_taken;
         ill_ff      <= !d_legal;
         next_pc_ff  <= (d_legal && d_taken) ? target : seq_pc;
      end
      else
      begin
         resolved_ff <= 1'b0;
         if (go)
            done_ff <= 1'b0;
      end
   end

   assign resolved     = resolved_ff;
   assign branch_taken = taken_ff;
   assign redirect_pc  = next_pc_ff;
endmodule // bru_top
`default_nettype wire
